// file: rtl/dil_map.svh
`ifndef DIL_MAP_SVH
`define DIL_MAP_SVH

// byte stride of one pixel word in the frame store (4 bytes)
`define DIL_WORD_SHIFT    2
// first byte address of the frame store
`define DIL_FRAME_BASE    32'h0000_0000
// reset values
`define DIL_RST_VALID     1'b0
`define DIL_RST_IDX       0

`endif

// file: rtl/dil_pkg.sv
package dil_pkg;

  // frame-store path states
  typedef enum logic [1:0] {
    DIL_ST_IDLE  = 2'b00,
    DIL_ST_WRITE = 2'b01,
    DIL_ST_READ  = 2'b10
  } dil_state_e;

endpackage

// file: rtl/dil_if.sv
`timescale 1ns/1ps
interface dil_if #(
  parameter int DW = 24,
  parameter int AW = 32
);
  // pixel stream in
  logic [DW-1:0] in_data;
  logic          in_valid;
  logic          in_ready;
  // pixel stream out
  logic [DW-1:0] out_data;
  logic          out_valid;
  logic          out_ready;
  // frame-fetch master
  logic [AW-1:0] rd_addr;
  logic          rd_read;
  logic [DW-1:0] rd_data;
  logic          rd_datavalid;
  logic          rd_wait;
  // frame-store master
  logic [AW-1:0] wr_addr;
  logic          wr_write;
  logic [DW-1:0] wr_data;
  logic          wr_wait;

  modport dev (
    input  in_data, in_valid, out_ready, rd_data, rd_datavalid, rd_wait, wr_wait,
    output in_ready, out_data, out_valid, rd_addr, rd_read, wr_addr, wr_write, wr_data
  );
  modport sys (
    output in_data, in_valid, out_ready, rd_data, rd_datavalid, rd_wait, wr_wait,
    input  in_ready, out_data, out_valid, rd_addr, rd_read, wr_addr, wr_write, wr_data
  );
endinterface

// file: rtl/dil_dev.sv
`timescale 1ns/1ps
`include "dil_map.svh"
module dil_dev
  import dil_pkg::*;
#(
  parameter int DW          = 24,
  parameter int AW          = 32,
  parameter bit WEAVE_EN    = 1'b1,
  parameter int MAX_RD      = 4,
  parameter int FRAME_WORDS = 1024
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // link
  dil_if.dev        lnk
);

  if (DW < 1) begin : g_chk_dw
    $error("DW must be at least 1");
  end

  if (AW <= `DIL_WORD_SHIFT) begin : g_chk_aw
    $error("AW too narrow for the word stride");
  end

  if (MAX_RD < 2 || (MAX_RD & (MAX_RD - 1)) != 0) begin : g_chk_rd
    $error("MAX_RD must be a power of two, at least 2");
  end
  if (FRAME_WORDS < 1 || (FRAME_WORDS << `DIL_WORD_SHIFT) > (2.0 ** AW)) begin : g_chk_fr
    $error("FRAME_WORDS does not fit the address width");
  end

  if (WEAVE_EN) begin : g_weave
    localparam int PW = $clog2(MAX_RD);
    localparam int IW = $clog2(FRAME_WORDS + 1);

    dil_state_e        state_q;
    dil_state_e        state_d;
    logic [IW-1:0]     idx_q;
    logic [IW-1:0]     idx_d;
    logic [AW-1:0]     addr_q;
    logic [AW-1:0]     addr_d;
    logic [DW-1:0]     data_q;
    logic [DW-1:0]     data_d;
    logic [PW:0]       cred_q;
    logic [PW:0]       cred_d;
    logic [PW:0]       fill_q;
    logic [PW:0]       fill_d;
    logic [PW-1:0]     head_q;
    logic [PW-1:0]     head_d;
    logic [PW-1:0]     tail_q;
    logic [PW-1:0]     tail_d;
    logic [DW-1:0]     ret_mem [MAX_RD];
    logic              issue;
    logic              pop;

    // byte address of frame-store word idx
    function automatic logic [AW-1:0] word_addr(input logic [IW-1:0] idx);
      return AW'(`DIL_FRAME_BASE + (AW'(idx) << `DIL_WORD_SHIFT));
    endfunction

    // frame index advance, wraps at the frame end
    function automatic logic [IW-1:0] next_idx(input logic [IW-1:0] idx);
      return (idx == IW'(FRAME_WORDS - 1)) ? IW'(`DIL_RST_IDX) : idx + 1'b1;
    endfunction

    // occupancy counter moved by one-cycle events
    function automatic logic [PW:0] step_cnt(input logic [PW:0] cnt, input logic up, input logic down);
      return cnt + (PW+1)'(up) - (PW+1)'(down);
    endfunction

    // ring pointer advance, wraps at MAX_RD
    function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] ptr, input logic adv);
      return ptr + PW'(adv);
    endfunction

    // request strobes; the address and data registers only move in IDLE
    assign lnk.in_ready  = (state_q == DIL_ST_IDLE);
    assign lnk.wr_write  = (state_q == DIL_ST_WRITE);
    assign lnk.wr_addr   = addr_q;
    assign lnk.wr_data   = data_q;
    // credit counts reads in flight plus words waiting, so returns never overflow
    assign lnk.rd_read   = (state_q == DIL_ST_READ) && (cred_q < (PW+1)'(MAX_RD));
    assign lnk.rd_addr   = addr_q;
    assign lnk.out_valid = (fill_q != '0);
    assign lnk.out_data  = ret_mem[head_q];
    assign issue         = lnk.rd_read && !lnk.rd_wait;
    assign pop           = lnk.out_valid && lnk.out_ready;

    always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      addr_d  = addr_q;
      data_d  = data_q;
      unique case (state_q)
        DIL_ST_IDLE: begin
          if (lnk.in_valid) begin
            data_d  = lnk.in_data;
            addr_d  = word_addr(idx_q);
            state_d = DIL_ST_WRITE;
          end
        end
        DIL_ST_WRITE: begin
          if (!lnk.wr_wait) begin
            state_d = DIL_ST_READ;
          end
        end
        DIL_ST_READ: begin
          if (issue) begin
            state_d = DIL_ST_IDLE;
            idx_d   = next_idx(idx_q);
          end
        end
        default: begin
          state_d = DIL_ST_IDLE;
        end
      endcase
    end

    // return buffer bookkeeping
    always_comb begin
      cred_d = step_cnt(cred_q, issue, pop);
      fill_d = step_cnt(fill_q, lnk.rd_datavalid, pop);
      tail_d = step_ptr(tail_q, lnk.rd_datavalid);
      head_d = step_ptr(head_q, pop);
    end

    always_ff @(posedge clk_i or posedge srst_i) begin
      if (srst_i) begin
        state_q <= DIL_ST_IDLE;
        idx_q   <= IW'(`DIL_RST_IDX);
        addr_q  <= '0;
        data_q  <= '0;
      end else begin
        state_q <= state_d;
        idx_q   <= idx_d;
        addr_q  <= addr_d;
        data_q  <= data_d;
      end
    end

    always_ff @(posedge clk_i or posedge srst_i) begin
      if (srst_i) begin
        cred_q <= '0;
        fill_q <= '0;
        head_q <= '0;
        tail_q <= '0;
      end else begin
        cred_q <= cred_d;
        fill_q <= fill_d;
        head_q <= head_d;
        tail_q <= tail_d;
      end
    end

    always_ff @(posedge clk_i) begin
      if (lnk.rd_datavalid) begin
        ret_mem[tail_q] <= lnk.rd_data;
      end
    end

  end else begin : g_plain
    logic [DW-1:0] out_data_q;
    logic [DW-1:0] out_data_d;
    logic          out_valid_q;
    logic          out_valid_d;

    // masters left quiet when field merging is off
    assign lnk.rd_read   = 1'b0;
    assign lnk.rd_addr   = '0;
    assign lnk.wr_write  = 1'b0;
    assign lnk.wr_addr   = '0;
    assign lnk.wr_data   = '0;
    assign lnk.in_ready  = !out_valid_q || lnk.out_ready;
    assign lnk.out_valid = out_valid_q;
    assign lnk.out_data  = out_data_q;

    always_comb begin
      out_data_d  = out_data_q;
      out_valid_d = out_valid_q;
      if (lnk.in_ready) begin
        out_valid_d = lnk.in_valid;
        if (lnk.in_valid) begin
          out_data_d = lnk.in_data;
        end
      end
    end

    always_ff @(posedge clk_i or posedge srst_i) begin
      if (srst_i) begin
        out_valid_q <= `DIL_RST_VALID;
        out_data_q  <= '0;
      end else begin
        out_valid_q <= out_valid_d;
        out_data_q  <= out_data_d;
      end
    end
  end

endmodule

// file: rtl/dil_sys.sv
`timescale 1ns/1ps
`include "dil_map.svh"
module dil_sys
  import dil_pkg::*;
#(
  parameter int DW        = 24,
  parameter int AW        = 32,
  parameter int MEM_WORDS = 1024
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  // pixel source
  input  wire logic [DW-1:0] src_data_i,
  input  wire logic          src_valid_i,
  output logic               src_ready_o,
  // pixel sink
  output logic [DW-1:0]      snk_data_o,
  output logic               snk_valid_o,
  input  wire logic          snk_ready_i,
  // interconnect stall controls
  input  wire logic          rd_stall_i,
  input  wire logic          wr_stall_i,
  // link
  dil_if.sys                 lnk
);

  localparam int MW = $clog2(MEM_WORDS);

  if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_chk_mem
    $error("MEM_WORDS must be a power of two, at least 2");
  end

  logic [DW-1:0] src_data_q;
  logic [DW-1:0] src_data_d;
  logic          src_valid_q;
  logic          src_valid_d;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic          rdv_q;
  logic          rdv_d;
  logic [DW-1:0] mem [MEM_WORDS];
  logic          rd_take;
  logic          wr_take;

  // source register: valid only alongside its own word, held until taken
  assign src_ready_o  = !src_valid_q || lnk.in_ready;
  assign lnk.in_valid = src_valid_q;
  assign lnk.in_data  = src_data_q;
  assign snk_data_o   = lnk.out_data;
  assign snk_valid_o  = lnk.out_valid;
  assign lnk.out_ready = snk_ready_i;

  assign lnk.rd_wait  = rd_stall_i;
  assign lnk.wr_wait  = wr_stall_i;
  assign rd_take      = lnk.rd_read && !lnk.rd_wait;
  assign wr_take      = lnk.wr_write && !lnk.wr_wait;
  assign lnk.rd_datavalid = rdv_q;
  assign lnk.rd_data  = rdata_q;

  always_comb begin
    src_data_d  = src_data_q;
    src_valid_d = src_valid_q;
    if (src_ready_o) begin
      src_valid_d = src_valid_i;
      if (src_valid_i) begin
        src_data_d = src_data_i;
      end
    end
    // fixed one-cycle read latency keeps returns in request order
    rdv_d   = rd_take;
    rdata_d = rd_take ? mem[lnk.rd_addr[`DIL_WORD_SHIFT +: MW]] : rdata_q;
  end

  always_ff @(posedge clk_i or posedge srst_i) begin
    if (srst_i) begin
      src_valid_q <= `DIL_RST_VALID;
      src_data_q  <= '0;
      rdv_q       <= `DIL_RST_VALID;
      rdata_q     <= '0;
    end else begin
      src_valid_q <= src_valid_d;
      src_data_q  <= src_data_d;
      rdv_q       <= rdv_d;
      rdata_q     <= rdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_take) begin
      mem[lnk.wr_addr[`DIL_WORD_SHIFT +: MW]] <= lnk.wr_data;
    end
  end

endmodule

// file: test/dil_asserts.sv
`timescale 1ns/1ps
module dil_asserts #(
  parameter int DW = 24,
  parameter int AW = 32
) (
  // clock and reset
  input wire logic          clk_i,
  input wire logic          srst_i,
  // streams
  input wire logic          in_valid,
  input wire logic          in_ready,
  input wire logic [DW-1:0] out_data,
  input wire logic          out_valid,
  input wire logic          out_ready,
  // memory masters
  input wire logic [AW-1:0] rd_addr,
  input wire logic          rd_read,
  input wire logic          rd_datavalid,
  input wire logic          rd_wait,
  input wire logic [AW-1:0] wr_addr,
  input wire logic          wr_write,
  input wire logic [DW-1:0] wr_data,
  input wire logic          wr_wait
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_in_take;
    in_valid && in_ready;
  endsequence
  sequence s_rd_take;
    rd_read && !rd_wait;
  endsequence
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word not held");
  chk_rd_hold: assert property (rd_read && rd_wait |=> rd_read && $stable(rd_addr))
    else $error("read request not held");
  chk_wr_hold: assert property (wr_write && wr_wait |=> wr_write && $stable({wr_addr, wr_data}))
    else $error("write request not held");
  chk_take_store: assert property (s_in_take |=> wr_write)
    else $error("accepted word not stored");
  chk_busy_ready: assert property (wr_write |-> !in_ready)
    else $error("ready while storing");
  chk_rd_bytes: assert property (rd_read |-> rd_addr[1:0] == 2'h0)
    else $error("read address not word aligned");
  chk_wr_bytes: assert property (wr_write |-> wr_addr[1:0] == 2'h0)
    else $error("write address not word aligned");
  chk_rd_return: assert property (s_rd_take |=> rd_datavalid)
    else $error("read data not returned");
  chk_reset_idle: assert property (disable iff (1'b0) srst_i |-> !(out_valid | rd_read | wr_write | rd_datavalid))
    else $error("outputs active in reset");
endmodule

// file: test/tb_deinterlacer_port_shell.sv
`timescale 1ns/1ps
`include "dil_map.svh"
module tb_deinterlacer_port_shell;
  localparam int DW = 24;
  localparam int AW = 32;
  localparam int FW = 16;
  logic          clk_i;
  logic          srst_i;
  logic [DW-1:0] src_data_i;
  logic          src_valid_i;
  logic          src_ready_o;
  logic [DW-1:0] snk_data_o;
  logic          snk_valid_o;
  logic          snk_ready_i;
  logic          rd_stall_i;
  logic          wr_stall_i;
  int            err_count = 0;
  int            checks_done = 0;
  int            cyc = 0;
  int            wr_n = 0;
  logic [DW-1:0] q[$];
  logic [DW-1:0] p_data_i;
  logic          p_valid_i;
  logic          p_ready_o;
  logic [DW-1:0] p_snk_data_o;
  logic          p_snk_valid_o;
  logic          p_snk_ready_i;
  logic [DW-1:0] pq[$];

  dil_if #(.DW(DW), .AW(AW)) lnk_if ();
  dil_dev #(.DW(DW), .AW(AW), .WEAVE_EN(1'b1), .MAX_RD(4), .FRAME_WORDS(FW)) dil_dev_inst (
    .clk_i, .srst_i, .lnk(lnk_if));
  dil_sys #(.DW(DW), .AW(AW), .MEM_WORDS(FW)) dil_sys_inst (
    .clk_i, .srst_i, .src_data_i, .src_valid_i, .src_ready_o, .snk_data_o, .snk_valid_o,
    .snk_ready_i, .rd_stall_i, .wr_stall_i, .lnk(lnk_if));
  dil_asserts #(.DW(DW), .AW(AW)) dil_asserts_inst (
    .clk_i, .srst_i, .in_valid(lnk_if.in_valid), .in_ready(lnk_if.in_ready),
    .out_data(lnk_if.out_data), .out_valid(lnk_if.out_valid), .out_ready(lnk_if.out_ready),
    .rd_addr(lnk_if.rd_addr), .rd_read(lnk_if.rd_read), .rd_datavalid(lnk_if.rd_datavalid),
    .rd_wait(lnk_if.rd_wait), .wr_addr(lnk_if.wr_addr), .wr_write(lnk_if.wr_write),
    .wr_data(lnk_if.wr_data), .wr_wait(lnk_if.wr_wait));

  // second pair with field merging off
  if (1'b1) begin : g_plain_mode
    dil_if #(.DW(DW), .AW(AW)) lnk_if ();
    dil_dev #(.DW(DW), .AW(AW), .WEAVE_EN(1'b0), .MAX_RD(4), .FRAME_WORDS(FW)) dil_dev_inst (
      .clk_i, .srst_i, .lnk(lnk_if));
    dil_sys #(.DW(DW), .AW(AW), .MEM_WORDS(FW)) dil_sys_inst (
      .clk_i, .srst_i, .src_data_i(p_data_i), .src_valid_i(p_valid_i), .src_ready_o(p_ready_o),
      .snk_data_o(p_snk_data_o), .snk_valid_o(p_snk_valid_o), .snk_ready_i(p_snk_ready_i),
      .rd_stall_i, .wr_stall_i, .lnk(lnk_if));
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] exp_addr(input int n);
    return `DIL_FRAME_BASE + ((n % FW) << `DIL_WORD_SHIFT);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // percent chances: source valid, sink ready, interconnect stall
  task automatic run(input int n, input int pv, input int pr, input int ps);
    repeat (n) begin
      @(posedge clk_i);
      if (!src_valid_i || src_ready_o) begin
        src_valid_i <= ($urandom % 100) < pv;
        src_data_i  <= DW'($urandom);
      end
      if (!p_valid_i || p_ready_o) begin
        p_valid_i <= ($urandom % 100) < pv;
        p_data_i  <= DW'($urandom);
      end
      snk_ready_i <= ($urandom % 100) < pr;
      p_snk_ready_i <= ($urandom % 100) < pr;
      rd_stall_i  <= ($urandom % 100) < ps;
      wr_stall_i  <= ($urandom % 100) < ps;
    end
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      q.delete();
      pq.delete();
      wr_n = 0;
    end else begin
      if (src_valid_i && src_ready_o) q.push_back(src_data_i);
      if (snk_valid_o && snk_ready_i) begin
        if (q.size() == 0) check(snk_valid_o, 1'b0);
        else check(snk_data_o, q.pop_front());
      end
      if (lnk_if.wr_write && !lnk_if.wr_wait) begin
        check(lnk_if.wr_addr, exp_addr(wr_n));
        wr_n++;
      end
      if (p_valid_i && p_ready_o) pq.push_back(p_data_i);
      if (p_snk_valid_o && p_snk_ready_i) begin
        if (pq.size() == 0) check(p_snk_valid_o, 1'b0);
        else check(p_snk_data_o, pq.pop_front());
      end
      check({g_plain_mode.lnk_if.rd_read, g_plain_mode.lnk_if.wr_write}, 32'h0);
    end
  end

  initial begin
    void'($urandom(96362));
    srst_i = 1'b0;
    src_data_i = '0;
    src_valid_i = 1'b0;
    snk_ready_i = 1'b0;
    p_data_i = '0;
    p_valid_i = 1'b0;
    p_snk_ready_i = 1'b0;
    rd_stall_i = 1'b0;
    wr_stall_i = 1'b0;
    // clean rising reset after all processes wait on it
    #1 srst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    check(snk_valid_o, 1'b0);
    check(p_snk_valid_o, 1'b0);
    check(src_ready_o, 1'b1);
    check(p_ready_o, 1'b1);
    srst_i <= 1'b0;
    run(100, 70, 60, 30);
    $display("test random traffic done");
    // sink stalled until the read credits run out, then drained
    run(40, 90, 0, 0);
    run(60, 0, 100, 0);
    check(q.size(), 0);
    check(pq.size(), 0);
    $display("test sink stall done");
    run(10, 90, 50, 20);
    @(posedge clk_i);
    srst_i <= 1'b1;
    src_valid_i <= 1'b0;
    p_valid_i <= 1'b0;
    #1 check(snk_valid_o | p_snk_valid_o | lnk_if.wr_write | lnk_if.rd_read, 1'b0);
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    run(80, 70, 70, 20);
    run(60, 0, 100, 0);
    check(q.size(), 0);
    check(pq.size(), 0);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
